// *** logic/sme_engine.v ***
// Two-wire bus protocol engine: master and addressed slave on open-drain SCL/SDA.
// Assumes external pull-ups, a 125 MHz ref_clk and that the pad resolves the
// wire from the output enables; bus pins are asynchronous and are synchronised.
`timescale 1ns/1ps
`include "sme_defs.vh"

module sme_engine #(
  parameter [6:0] OWN_ADDR = `SME_OWN_ADDR,
  parameter [15:0] HALF_CYC = `SME_HALF_CYC,
  parameter [15:0] FREE_CYC = `SME_FREE_CYC,
  parameter [21:0] TOUT_CYC = `SME_TOUT_CYC,
  parameter FIFO_DEPTH = `SME_FIFO_DEPTH,
  parameter FIFO_AW = `SME_FIFO_AW
) (
  input wire ref_clk,
  input wire srst,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  input wire cmd_valid,
  input wire [6:0] cmd_addr,
  input wire cmd_rd,
  input wire [7:0] cmd_len,
  output reg cmd_ready,
  input wire tx_valid,
  input wire [7:0] tx_data,
  output wire tx_ready,
  output reg rx_valid,
  output reg [7:0] rx_data,
  output reg rx_slave,
  output reg bus_busy,
  output reg slave_sel,
  output reg done,
  output reg nack,
  output reg arb_lost,
  output reg timeout
);

  // Master states
  localparam [2:0] M_IDLE = 3'd0;
  localparam [2:0] M_START = 3'd1;
  localparam [2:0] M_LOW = 3'd2;
  localparam [2:0] M_HIGH = 3'd3;
  localparam [2:0] M_STOP = 3'd4;
  localparam [2:0] M_STOPH = 3'd5;
  // Slave bit counter value meaning "before first bit of a frame"
  localparam [3:0] S_PRE = 4'hF;

  // ==========================================================
  // Pin synchronisers and edge detection
  // ==========================================================
  wire scl_s;
  wire sda_s;
  reg scl_p_q;
  reg sda_p_q;

  sme_sync u_scl_sync (
    .clk(ref_clk),
    .rst(srst),
    .d(scl_i),
    .q(scl_s)
  );

  sme_sync u_sda_sync (
    .clk(ref_clk),
    .rst(srst),
    .d(sda_i),
    .q(sda_s)
  );

  // Conditions seen on the wire, from any master
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;

  // Previous synchronised levels
  always @(posedge ref_clk) begin
    if (srst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ==========================================================
  // Bus free and clock-low timeout
  // ==========================================================
  reg [15:0] free_cnt_q;
  reg free_q;
  reg [21:0] low_cnt_q;
  // One-cycle hit when SCL has been low for the whole timeout
  wire tout_hit = ~scl_s & (low_cnt_q == TOUT_CYC - 22'd1);

  // Free after STOP, or after both lines high long enough; reset starts busy
  always @(posedge ref_clk) begin
    if (srst) begin
      free_cnt_q <= 16'h0000;
      free_q <= 1'b0;
    end else if (start_det) begin
      free_cnt_q <= 16'h0000;
      free_q <= 1'b0;
    end else if (stop_det) begin
      free_q <= 1'b1;
    end else if (scl_s & sda_s) begin
      if (free_cnt_q < FREE_CYC)
        free_cnt_q <= free_cnt_q + 16'h0001;
      else
        free_q <= 1'b1;
    end else begin
      free_cnt_q <= 16'h0000;
    end
  end

  always @(posedge ref_clk) begin
    if (srst)
      low_cnt_q <= 22'h000000;
    else if (scl_s)
      low_cnt_q <= 22'h000000;
    else if (low_cnt_q != TOUT_CYC)
      low_cnt_q <= low_cnt_q + 22'h000001;
  end

  // ==========================================================
  // Transmit buffer
  // ==========================================================
  wire f_valid;
  wire [7:0] f_data;
  wire f_ready;

  sme_fifo #(
    .W(`SME_BYTE_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(ref_clk),
    .rst(srst),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  // ==========================================================
  // Master sequencer
  // ==========================================================
  reg [2:0] st_q;
  reg [15:0] tmr_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] left_q;
  reg rd_q;
  reg addr_ph_q;
  reg rx_mode_q;
  reg need_q;
  reg ackn_q;
  reg mscl_q;
  reg msda_q;
  reg m_lost;
  reg m_nack;
  reg m_done;
  wire mst_act = (st_q != M_IDLE);
  wire take = cmd_valid & cmd_ready & ~mst_act & free_q;
  wire tmr_end = (tmr_q == HALF_CYC - 16'h0001);
  // First cycle of an observed high phase is where the wire is sampled
  wire hi_samp = (st_q == M_HIGH) & scl_s & (tmr_q == 16'h0000);
  wire m_rx_ev = hi_samp & rx_mode_q & (bit_q == 4'd7);
  // Byte pulled from the buffer when a write data byte begins
  wire m_pop = (st_q == M_LOW) & need_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      st_q <= M_IDLE;
      tmr_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      left_q <= 8'h00;
      rd_q <= 1'b0;
      addr_ph_q <= 1'b0;
      rx_mode_q <= 1'b0;
      need_q <= 1'b0;
      ackn_q <= 1'b0;
      mscl_q <= 1'b0;
      msda_q <= 1'b0;
      m_lost <= 1'b0;
      m_nack <= 1'b0;
      m_done <= 1'b0;
    end else begin
      m_lost <= 1'b0;
      m_nack <= 1'b0;
      m_done <= 1'b0;
      if (tout_hit) begin
        st_q <= M_IDLE;
        mscl_q <= 1'b0;
        msda_q <= 1'b0;
      end else begin
        case (st_q)
          M_IDLE: begin
            mscl_q <= 1'b0;
            msda_q <= 1'b0;
            if (take) begin
              sh_q <= {cmd_addr, cmd_rd};
              rd_q <= cmd_rd;
              left_q <= cmd_len;
              addr_ph_q <= 1'b1;
              rx_mode_q <= 1'b0;
              need_q <= 1'b0;
              bit_q <= 4'h0;
              tmr_q <= 16'h0000;
              msda_q <= 1'b1;
              st_q <= M_START;
            end
          end
          M_START: begin
            tmr_q <= tmr_q + 16'h0001;
            if (tmr_end) begin
              mscl_q <= 1'b1;
              tmr_q <= 16'h0000;
              st_q <= M_LOW;
            end
          end
          M_LOW: begin
            // Own clock held low while the buffer is empty
            if (need_q) begin
              if (f_valid) begin
                sh_q <= f_data;
                need_q <= 1'b0;
              end
            end else begin
              tmr_q <= tmr_q + 16'h0001;
              if (tmr_q == 16'h0000) begin
                if (bit_q == 4'd8)
                  // Ack all but the last read byte
                  msda_q <= rx_mode_q & (left_q != 8'h00);
                else
                  msda_q <= ~rx_mode_q & ~sh_q[7];
              end
              if (tmr_end) begin
                mscl_q <= 1'b0;
                tmr_q <= 16'h0000;
                st_q <= M_HIGH;
              end
            end
          end
          M_HIGH: begin
            if (scl_s) begin
              tmr_q <= tmr_q + 16'h0001;
              if (tmr_q == 16'h0000) begin
                if (bit_q == 4'd8) begin
                  ackn_q <= sda_s;
                end else if (rx_mode_q) begin
                  sh_q <= {sh_q[6:0], sda_s};
                end else if (sh_q[7] & ~sda_s) begin
                  m_lost <= 1'b1;
                  mscl_q <= 1'b0;
                  msda_q <= 1'b0;
                  st_q <= M_IDLE;
                end else begin
                  sh_q <= {sh_q[6:0], 1'b1};
                end
              end
              if (tmr_end) begin
                mscl_q <= 1'b1;
                tmr_q <= 16'h0000;
                st_q <= M_LOW;
                if (bit_q != 4'd8) begin
                  bit_q <= bit_q + 4'd1;
                end else begin
                  bit_q <= 4'h0;
                  if (~rx_mode_q & (ackn_q == `SME_NACK)) begin
                    m_nack <= 1'b1;
                    st_q <= M_STOP;
                  end else if (left_q == 8'h00) begin
                    st_q <= M_STOP;
                  end else begin
                    left_q <= left_q - 8'h01;
                    rx_mode_q <= (rd_q == `SME_DIR_READ);
                    need_q <= (rd_q == `SME_DIR_WRITE);
                    addr_ph_q <= 1'b0;
                  end
                end
              end
            end
          end
          M_STOP: begin
            tmr_q <= tmr_q + 16'h0001;
            if (tmr_q == 16'h0000)
              msda_q <= 1'b1;
            if (tmr_end) begin
              mscl_q <= 1'b0;
              tmr_q <= 16'h0000;
              st_q <= M_STOPH;
            end
          end
          M_STOPH: begin
            // SDA rises only after SCL is seen high
            if (scl_s) begin
              tmr_q <= tmr_q + 16'h0001;
              if (tmr_end) begin
                msda_q <= 1'b0;
                m_done <= 1'b1;
                st_q <= M_IDLE;
              end
            end
          end
          default: begin
            st_q <= M_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Slave listener
  // ==========================================================
  // Tracks each frame through its address byte, and past it only when addressed; whoever sent the START is treated as master
  reg s_on;
  reg s_sel;
  reg s_addr_ph;
  reg s_rd;
  reg [3:0] s_bit;
  reg [7:0] s_sh;
  reg s_drv;
  wire s_fall = s_on & scl_fall;
  wire s_rx_ev = s_fall & (s_bit == 4'd7) & ~s_addr_ph & s_sel & ~s_rd;
  wire s_pop = s_fall & (s_bit == 4'd8) & s_sel & s_rd;
  wire [7:0] s_next = f_valid ? f_data : `SME_IDLE_BYTE;

  assign f_ready = m_pop | s_pop;

  always @(posedge ref_clk) begin
    if (srst) begin
      s_on <= 1'b0;
      s_sel <= 1'b0;
      s_addr_ph <= 1'b0;
      s_rd <= 1'b0;
      s_bit <= S_PRE;
      s_sh <= 8'h00;
      s_drv <= 1'b0;
    end else if (tout_hit | stop_det) begin
      s_on <= 1'b0;
      s_sel <= 1'b0;
      s_drv <= 1'b0;
    end else if (start_det) begin
      s_on <= 1'b1;
      s_sel <= 1'b0;
      s_addr_ph <= 1'b1;
      s_bit <= S_PRE;
      s_drv <= 1'b0;
    end else if (s_on & scl_rise) begin
      if (s_bit < 4'd8)
        s_sh <= {s_sh[6:0], sda_s};
      else if (s_rd & sda_s)
        // Master nack: stop feeding bytes
        s_sel <= 1'b0;
    end else if (s_fall) begin
      if (s_bit == S_PRE) begin
        s_bit <= 4'h0;
      end else if (s_bit == 4'd7) begin
        s_bit <= 4'd8;
        s_drv <= 1'b0;
        if (s_addr_ph) begin
          s_addr_ph <= 1'b0;
          if ((s_sh[7:1] == OWN_ADDR) & ~mst_act) begin
            s_sel <= 1'b1;
            s_rd <= s_sh[0];
            s_drv <= 1'b1;
          end else begin
            s_on <= 1'b0;
          end
        end else if (s_sel & ~s_rd) begin
          s_drv <= 1'b1;
        end
      end else if (s_bit == 4'd8) begin
        s_bit <= 4'h0;
        s_drv <= 1'b0;
        if (s_sel & s_rd) begin
          s_sh <= s_next;
          s_drv <= ~s_next[7];
        end
      end else begin
        s_bit <= s_bit + 4'd1;
        s_drv <= s_sel & s_rd & ~s_sh[7];
      end
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  // One cycle of latency on the pads buys glitch-free, flop-driven enables
  always @(posedge ref_clk) begin
    if (srst) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      cmd_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_slave <= 1'b0;
      bus_busy <= 1'b1;
      slave_sel <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      arb_lost <= 1'b0;
      timeout <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= mscl_q & ~tout_hit;
      sda_oe <= (msda_q | (s_drv & ~mst_act)) & ~tout_hit;
      cmd_ready <= ~mst_act & free_q & ~take;
      rx_valid <= m_rx_ev | s_rx_ev;
      if (m_rx_ev) begin
        rx_data <= {sh_q[6:0], sda_s};
        rx_slave <= 1'b0;
      end else if (s_rx_ev) begin
        rx_data <= s_sh;
        rx_slave <= 1'b1;
      end
      bus_busy <= ~free_q;
      slave_sel <= s_sel;
      done <= m_done;
      nack <= m_nack;
      arb_lost <= m_lost;
      timeout <= tout_hit;
    end
  end

endmodule // sme_engine

// *** shared/sme_defs.vh ***
// Constants for the two-wire bus protocol engine: timing counts, byte layout.
// Assumes a 125 MHz system clock; every count is derived from the clock period here.
`ifndef SME_DEFS_VH
`define SME_DEFS_VH

// ==========================================================
// Clock and timing
// ==========================================================
// System clock period in ns
`define SME_CLK_NS 8
// Bus free interval in us, least time, rounded up
`define SME_FREE_US 50
`define SME_FREE_CYC ((`SME_FREE_US * 1000 + `SME_CLK_NS - 1) / `SME_CLK_NS)
// Clock-low timeout in ms, rounded down
`define SME_TOUT_MS 25
`define SME_TOUT_CYC ((`SME_TOUT_MS * 1000000) / `SME_CLK_NS)
// Half period of the serial clock we generate, in ns
`define SME_HALF_NS 5000
`define SME_HALF_CYC ((`SME_HALF_NS + `SME_CLK_NS - 1) / `SME_CLK_NS)

// ==========================================================
// Byte layout and bus levels
// ==========================================================
`define SME_BYTE_W 8
`define SME_ADDR_W 7
// Direction bit in address byte bit 0
`define SME_DIR_READ 1'b1
`define SME_DIR_WRITE 1'b0
// Ack slot level on SDA
`define SME_NACK 1'b1
// Own slave address, plain default
`define SME_OWN_ADDR 7'h2A
// Transmit buffer shape
`define SME_FIFO_DEPTH 16
`define SME_FIFO_AW 4
// Byte sent by the slave when its buffer runs dry
`define SME_IDLE_BYTE 8'hFF

`endif

// *** logic/sme_sync.v ***
// Two-flop synchroniser for one bus line.
// Assumes the line idles high, so both stages reset to one.
`timescale 1ns/1ps

module sme_sync (
  input wire clk,
  input wire rst,
  input wire d,
  output reg q
);

  // First stage, read only by the second stage
  reg meta_q;

  // ==========================================================
  // Two stages
  // ==========================================================
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // sme_sync

// *** logic/sme_fifo.v ***
// Transmit byte buffer with valid/ready on both sides.
// Assumes one clock; read data and valid come out of a register stage.
`timescale 1ns/1ps

module sme_fifo #(
  parameter W = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output reg in_ready,
  output reg out_valid,
  output reg [W-1:0] out_data,
  input wire out_ready
);

  // Storage and pointers
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] cnt_d;
  reg ov_d; // Output stage full after this edge
  wire push = in_valid & in_ready;
  // Move a word into the output stage when it is empty or being drained
  wire pop = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  // ==========================================================
  // Occupancy
  // ==========================================================
  always @* begin
    cnt_d = cnt_q;
    ov_d = pop | (out_valid & ~out_ready);
    if (push & ~pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop & ~push)
      cnt_d = cnt_q - 1'b1;
  end

  // Registered ready keeps the source honest: it drops when array and output stage together hold DEPTH words
  always @(posedge clk) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
      in_ready <= ((cnt_d + {{AW{1'b0}}, ov_d}) < DEPTH);
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      // Output register stage
      if (pop) begin
        out_data <= mem_q[rd_q];
        rd_q <= rd_q + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule // sme_fifo

// *** tb/sme_engine_monitor.sv ***
// Checker for the bus engine; it watches only the engine's ports.
// Assumes one ref_clk domain, srst synchronous and active high.
`timescale 1ns/1ps

module sme_engine_monitor #(
  parameter [15:0] HALF_CYC = 16'h0271,
  parameter [21:0] TOUT_CYC = 22'h2FAF08
) (
  input wire ref_clk,
  input wire srst,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire rx_valid,
  input wire rx_slave,
  input wire bus_busy,
  input wire done,
  input wire timeout
);
  // ====================
  // Run-length helpers
  // ====================
  reg [22:0] lo_q = 23'h000000; // SCL low run
  reg [15:0] hi_q = 16'h0000; // SCL high run, saturating
  reg tseen_q = 1'b0; // Timeout already flagged in this low run
  // Counts restart on reset so a stale run never leaks across it
  always @(posedge ref_clk) begin
    lo_q <= (srst || scl_i) ? 23'h000000 : lo_q + 23'h000001;
    hi_q <= (srst || !scl_i) ? 16'h0000 : hi_q + {15'h0000, hi_q != 16'hFFFF};
    tseen_q <= (srst || scl_i) ? 1'b0 : (tseen_q | timeout);
  end

  // ====================
  // Properties
  // ====================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_take; cmd_valid && cmd_ready; endsequence
  sequence s_start; sda_oe && !scl_oe; endsequence
  property p_od; !scl_o && !sda_o; endproperty
  property p_free; cmd_ready |-> !bus_busy; endproperty
  property p_start; s_take |-> ##[1:3] s_start; endproperty
  property p_clk; s_take ##[1:3] s_start |-> !scl_oe [*8] ##[1:700] scl_oe; endproperty
  property p_stretch; $rose(scl_oe) |-> hi_q >= HALF_CYC; endproperty
  property p_done; done |-> scl_i && sda_i && !scl_oe && !sda_oe; endproperty
  property p_tearly; timeout |-> lo_q >= TOUT_CYC && lo_q <= TOUT_CYC + 6; endproperty
  property p_tlate; lo_q <= TOUT_CYC + 6 || tseen_q; endproperty
  property p_trec; timeout |-> ##[0:2] (!scl_oe && !sda_oe); endproperty
  property p_sack; rx_valid && rx_slave |-> ##[0:8] sda_oe; endproperty
  a_od: assert property (p_od) else $error("bus pin data output not low");
  a_free: assert property (p_free) else $error("ready while bus busy");
  a_start: assert property (p_start) else $error("no start after command");
  a_clk: assert property (p_clk) else $error("clock not begun after start");
  a_stretch: assert property (p_stretch) else $error("clock high phase cut short");
  a_done: assert property (p_done) else $error("done without bus released");
  a_tearly: assert property (p_tearly) else $error("timeout at wrong low count");
  a_tlate: assert property (p_tlate) else $error("timeout missing");
  a_trec: assert property (p_trec) else $error("pins held after timeout");
  a_sack: assert property (p_sack) else $error("slave byte not acknowledged");
endmodule // sme_engine_monitor

bind sme_engine sme_engine_monitor #(.HALF_CYC(HALF_CYC), .TOUT_CYC(TOUT_CYC)) u_sme_engine_monitor (
  .ref_clk(ref_clk), .srst(srst), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rx_valid(rx_valid),
  .rx_slave(rx_slave), .bus_busy(bus_busy), .done(done), .timeout(timeout));

// *** tb/sme_slave_model.sv ***
// Behavioural slave device facing the engine's master.
// Assumes the bench resolves the open-drain wires with pull-ups.
`timescale 1ns/1ps

module sme_slave_model #(
  parameter [6:0] ADDR = 7'h50,
  parameter [7:0] STR_CYC = 8'h1E
) (
  input wire clk,
  input wire scl,
  input wire sda,
  input wire stretch,
  input wire hang,
  output reg scl_pull,
  output reg sda_pull,
  output reg [7:0] wr_cnt,
  output reg [7:0] wr_sum,
  output reg [7:0] wr_last
);
  reg scl_q = 1'b1; // Previous SCL
  reg sda_q = 1'b1; // Previous SDA
  reg [3:0] bit_q = 4'h0; // Bits seen, ninth is the ack slot
  reg [7:0] sh_q = 8'h00; // Incoming shift
  reg [7:0] tx_q = 8'h00; // Reply byte on the wire
  reg [7:0] rd_q = 8'hA5; // Next reply byte
  reg [7:0] str_q = 8'h00; // Stretch countdown
  reg adr_q = 1'b1; // Address phase
  reg act_q = 1'b0; // Addressed
  reg dir_q = 1'b0; // Read direction
  wire fall = scl_q && !scl;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    wr_cnt = 8'h00;
    wr_sum = 8'h00;
    wr_last = 8'h00;
  end
  // ====================
  // Bus behaviour
  // ====================
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    str_q <= (fall && stretch) ? STR_CYC : (str_q != 8'h00) ? str_q - 8'h01 : 8'h00;
    scl_pull <= (hang && (scl_pull || fall)) || (str_q != 8'h00);
    if (scl && scl_q && sda_q && !sda) begin
      bit_q <= 4'h0;
      adr_q <= 1'b1;
      act_q <= 1'b0;
      sda_pull <= 1'b0;
      rd_q <= 8'hA5;
    end else if (scl && scl_q && !sda_q && sda) begin
      act_q <= 1'b0;
      sda_pull <= 1'b0;
    end else if (!scl_q && scl) begin
      bit_q <= bit_q + 4'h1;
      if (bit_q < 4'h8) sh_q <= {sh_q[6:0], sda};
      else if (act_q && dir_q && !adr_q && sda) act_q <= 1'b0;
    end else if (fall) begin
      if (bit_q == 4'h8 && adr_q) begin
        act_q <= sh_q[7:1] == ADDR;
        dir_q <= sh_q[0];
        sda_pull <= sh_q[7:1] == ADDR;
      end else if (bit_q == 4'h8) begin
        sda_pull <= act_q && !dir_q;
        if (act_q && !dir_q) begin
          wr_cnt <= wr_cnt + 8'h01;
          wr_sum <= wr_sum + sh_q;
          wr_last <= sh_q;
        end
      end else if (bit_q == 4'h9) begin
        bit_q <= 4'h0;
        adr_q <= 1'b0;
        tx_q <= rd_q;
        rd_q <= rd_q + {7'h00, act_q && dir_q};
        sda_pull <= act_q && dir_q && !rd_q[7];
      end else if (act_q && dir_q) begin
        sda_pull <= !tx_q[3'h7 - bit_q[2:0]];
      end
    end
  end
endmodule // sme_slave_model

// *** tb/sme_engine_tb.sv ***
// Self-checking bench for the bus engine with a slave model on the wires.
// Assumes shortened timing parameters; the bench also plays a foreign master.
`timescale 1ns/1ps

module sme_engine_tb;
  localparam [6:0] PADDR = 7'h50; // Model's address
  localparam [6:0] SADDR = 7'h2A; // Engine's own address
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg cmd_valid = 1'b0;
  reg [6:0] cmd_addr = 7'h00;
  reg cmd_rd = 1'b0;
  reg [7:0] cmd_len = 8'h00;
  reg tx_valid = 1'b0;
  reg [7:0] tx_data = 8'h00;
  reg tb_scl = 1'b0; // Bench pulls SCL low
  reg tb_sda = 1'b0; // Bench pulls SDA low
  reg stretch = 1'b0;
  reg hang = 1'b0;
  wire scl_o, scl_oe, sda_o, sda_oe, cmd_ready, tx_ready, rx_valid, rx_slave;
  wire bus_busy, slave_sel, done, nack, arb_lost, timeout, p_scl, p_sda;
  wire [7:0] rx_data, wr_cnt, wr_sum, wr_last;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  logic [8:0] rxq[$]; // Received bytes with slave flag
  wire scl_w = !(scl_oe || p_scl || tb_scl);
  wire sda_w = !(sda_oe || p_sda || tb_sda);

  sme_engine #(.OWN_ADDR(SADDR), .HALF_CYC(16'h000A), .FREE_CYC(16'h0028), .TOUT_CYC(22'h0007D0)) u_sme_engine (
    .ref_clk(ref_clk), .srst(srst), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_rd(cmd_rd),
    .cmd_len(cmd_len), .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_slave(rx_slave), .bus_busy(bus_busy),
    .slave_sel(slave_sel), .done(done), .nack(nack), .arb_lost(arb_lost), .timeout(timeout));
  sme_slave_model #(.ADDR(PADDR)) u_sme_slave_model (
    .clk(ref_clk), .scl(scl_w), .sda(sda_w), .stretch(stretch), .hang(hang), .scl_pull(p_scl),
    .sda_pull(p_sda), .wr_cnt(wr_cnt), .wr_sum(wr_sum), .wr_last(wr_last));

  // ====================
  // Clock, watchdog, capture
  // ====================
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (rx_valid === 1'b1) rxq.push_back({rx_slave, rx_data});
    // A hang counts as a mismatch and closes the run
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end

  // ====================
  // Shared tasks
  // ====================
  task wrap_up;
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Outputs are read just after an edge, so they hold pre-edge values
  task wait_rdy;
    integer k;
    begin
      k = 0;
      while (cmd_ready !== 1'b1 && k < 5000) begin
        tick(1);
        k = k + 1;
      end
    end
  endtask
  task run_cmd(input [6:0] a, input r, input [7:0] len, output [3:0] ev);
    integer k;
    begin
      wait_rdy;
      cmd_addr <= a;
      cmd_rd <= r;
      cmd_len <= len;
      cmd_valid <= 1'b1;
      tick(1);
      cmd_valid <= 1'b0;
      ev = 4'h0;
      k = 0;
      while (ev == 4'h0 && k < 20000) begin
        tick(1);
        ev = {done, nack, arb_lost, timeout};
        k = k + 1;
      end
    end
  endtask
  // One bit as a foreign master at the 160 ns link period
  task sbit(input b, output s);
    tb_sda <= !b;
    tick(5);
    tb_scl <= 1'b0;
    tick(10);
    s = sda_w;
    tb_scl <= 1'b1;
    tick(5);
  endtask
  task sbyte(input [7:0] v, output ack);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) sbit(v[i], s);
      sbit(1'b1, s);
      ack = !s;
    end
  endtask

  // ====================
  // Scenarios
  // ====================
  task t_reset;
    integer k;
    begin
      tick(1);
      chk("reset outputs", 16'h0020, {bus_busy, cmd_ready, scl_oe, sda_oe, done, timeout});
      k = 0;
      while (cmd_ready !== 1'b1 && k < 200) begin
        tick(1);
        k = k + 1;
      end
      chk("free delay in range", 1, k >= 40 && k <= 60);
    end
  endtask
  // Fill the buffer until it refuses, then drain it over a stretched write
  task t_write;
    integer k;
    integer n;
    reg [3:0] ev;
    begin
      n = 0;
      tx_data <= 8'h30;
      tx_valid <= 1'b1;
      for (k = 0; k < 20; k = k + 1) begin
        tick(1);
        if (tx_ready === 1'b1) n = n + 1;
        tx_data <= 8'h30 + n[7:0];
      end
      tx_valid <= 1'b0;
      chk("buffer accepted", 16, n);
      chk("buffer full", 0, tx_ready);
      stretch <= 1'b1;
      run_cmd(PADDR, 1'b0, 8'h10, ev);
      stretch <= 1'b0;
      chk("write end event", 4'h8, ev);
      chk("bytes written", 8'h10, wr_cnt);
      chk("byte sum", 8'h78, wr_sum);
      chk("last byte", 8'h3F, wr_last);
      chk("buffer drained", 1, tx_ready);
    end
  endtask
  task t_read;
    reg [3:0] ev;
    begin
      run_cmd(PADDR, 1'b1, 8'h02, ev);
      chk("read end event", 4'h8, ev);
      chk("read count", 2, rxq.size());
      chk("read byte 0", 16'h00A5, rxq.pop_front());
      chk("read byte 1", 16'h00A6, rxq.pop_front());
    end
  endtask
  task t_nack;
    reg [3:0] ev;
    begin
      run_cmd(7'h11, 1'b0, 8'h01, ev);
      chk("address nack event", 4'h4, ev);
    end
  endtask
  task t_slave;
    reg a;
    begin
      wait_rdy;
      tb_sda <= 1'b1;
      tick(10);
      tb_scl <= 1'b1;
      tick(5);
      sbyte({SADDR, 1'b0}, a);
      chk("slave address ack", 1, a);
      chk("slave selected", 1, slave_sel);
      sbyte(8'h5C, a);
      chk("slave data ack", 1, a);
      tb_sda <= 1'b1;
      tick(5);
      tb_scl <= 1'b0;
      tick(10);
      tb_sda <= 1'b0;
      tick(4);
      chk("slave rx count", 1, rxq.size());
      chk("slave rx byte", 16'h015C, rxq.pop_front());
    end
  endtask
  // Model holds SCL low for good; the engine must give up and recover
  task t_tout;
    reg [3:0] ev;
    begin
      tx_data <= 8'h77;
      tx_valid <= 1'b1;
      tick(1);
      tx_valid <= 1'b0;
      hang <= 1'b1;
      run_cmd(PADDR, 1'b0, 8'h01, ev);
      chk("timeout event", 4'h1, ev);
      tick(2);
      chk("pins released", 0, {scl_oe, sda_oe});
      hang <= 1'b0;
      wait_rdy;
      chk("ready again", 1, cmd_ready);
    end
  endtask

  initial begin
    tick(2);
    srst <= 1'b0;
    t_reset;
    t_write;
    t_read;
    t_nack;
    t_slave;
    t_tout;
    wrap_up;
  end
endmodule // sme_engine_tb
